/* File: eti_pkg.sv */
`default_nettype none
package eti_pkg;

  // ------------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] ETI_OFS_EXTI_HI = 8'h00;
  localparam logic [7:0] ETI_OFS_CMP = 8'h04;
  localparam logic [7:0] ETI_OFS_SMALL_TMR = 8'h08;
  localparam logic [7:0] ETI_OFS_MAIN_TMR = 8'h0c;

  // ------------------------------------------------------------------
  // reset values and writable bits (reserved bits hold zero)
  // ------------------------------------------------------------------
  localparam logic [31:0] ETI_RST_EXTI_HI = 32'h0000_0000;
  localparam logic [31:0] ETI_RST_CMP = 32'h0000_0000;
  localparam logic [31:0] ETI_RST_SMALL_TMR = 32'h0000_0000;
  localparam logic [31:0] ETI_RST_MAIN_TMR = 32'h0000_0000;
  localparam logic [31:0] ETI_MSK_EXTI_HI = 32'h0000_ffff;
  localparam logic [31:0] ETI_MSK_CMP = 32'h0c00_0000;
  localparam logic [31:0] ETI_MSK_SMALL_TMR = 32'h0000_0fff;
  localparam logic [31:0] ETI_MSK_MAIN_TMR = 32'h000f_007f;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int ETI_EXTI15_LSB = 12;
  localparam int ETI_EXTI14_LSB = 8;
  localparam int ETI_EXTI13_LSB = 4;
  localparam int ETI_EXTI12_LSB = 0;
  localparam int ETI_CMP_LSB = 26;
  localparam int ETI_T11_LSB = 8;
  localparam int ETI_T10_LSB = 4;
  localparam int ETI_T9_LSB = 0;
  localparam int ETI_T5CH4_BIT = 19;
  localparam int ETI_T5_LSB = 16;
  localparam int ETI_T2_LSB = 4;
  localparam int ETI_T1_LSB = 0;

  // ------------------------------------------------------------------
  // field codes
  // ------------------------------------------------------------------
  localparam logic [3:0] ETI_PORT_A = 4'h0;
  localparam logic [3:0] ETI_PORT_B = 4'h1;
  localparam logic [3:0] ETI_PORT_C = 4'h2;
  localparam logic [3:0] ETI_PORT_D = 4'h3;
  localparam logic [3:0] ETI_PORT_F = 4'h4;
  localparam logic [1:0] ETI_CMP_PA0_PA2 = 2'h0;
  localparam logic [1:0] ETI_CMP_PA6_PA7 = 2'h1;
  localparam logic [1:0] ETI_CMP_PA11_PA12 = 2'h2;
  localparam logic [3:0] ETI_SMALL_ALT = 4'h2;
  localparam logic [2:0] ETI_T5_ALT = 3'h1;
  localparam logic [3:0] ETI_T1_SET0 = 4'h0;
  localparam logic [3:0] ETI_T1_SET1 = 4'h1;
  localparam logic [3:0] ETI_T1_SET2 = 4'h2;

  // ------------------------------------------------------------------
  // bus responses
  // ------------------------------------------------------------------
  localparam logic [1:0] ETI_RESP_OKAY = 2'h0;
  localparam logic [1:0] ETI_RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] pf;
    logic [15:0] pd;
    logic [15:0] pc;
    logic [15:0] pb;
    logic [15:0] pa;
  } eti_pins_t;

  typedef struct packed {
    logic t1_ext;
    logic [3:0] t1_ch;
    logic t1_brk;
    logic [3:0] t2_ch;
    logic [3:0] t5_ch;
    logic [1:0] t9_ch;
    logic t10_ch1;
    logic t11_ch1;
  } eti_tmr_t;

  typedef struct packed {
    logic [15:0] pa_val;
    logic [15:0] pa_oe;
    logic [15:0] pb_val;
    logic [15:0] pb_oe;
  } eti_drive_t;

endpackage : eti_pkg
`default_nettype wire

/* File: eti_remap_top.sv */
// Function
// - line 15 source: pin 15 of A,B,C,D,F
// - line 14 source: pin 14 of A,B,C,D,F
// - line 13 source: pin 13 of A,B,C,D,F
// - line 12 source: pin 12 of A,B,C,D,F
// - comparator outputs on PA0/2, PA6/7, PA11/12
// - timer 11 ch1 on PB9 or PA7
// - timer 10 ch1 on PB8 or PA6
// - timer 9 ch1/2 on PA2/3 or PB14/15
// - timer 5 ch4 from PA3 or oscillator
// - timer 5 ch1/2 on PA0/1 or PF4/5
// - timer 2 four pin combinations
// - timer 1 three pin sets
`timescale 1ns/1ps
`default_nettype none
module eti_remap_top #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire eti_pkg::eti_pins_t pins_in,
  input wire logic comparator_one_output_in,
  input wire logic comparator_two_output_in,
  input wire logic [2:0] complementary_channel_in,
  input wire logic low_speed_rc_oscillator_in,
  output logic [15:12] ext_irq_line_source_out,
  output eti_pkg::eti_tmr_t timer_inputs_out,
  output eti_pkg::eti_drive_t pin_drive_out
);

  // ------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie between 8 and 32");
  end

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] exti_src_sel_hi;
    logic [31:0] comparator_out_remap;
    logic [31:0] small_timer_remap;
    logic [31:0] main_timer_remap;
    logic awready;
    logic wready;
    logic bvalid;
    logic arready;
    logic rvalid;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [15:12] irq_src;
    eti_pkg::eti_tmr_t tmr;
    eti_pkg::eti_drive_t drv;
  } eti_state_t;

  eti_state_t s_r;
  eti_state_t s_nxt;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // pin n of the port chosen by a four-bit source code
  function automatic logic eti_pick(input eti_pkg::eti_pins_t p,
                                    input logic [3:0] code,
                                    input int pin);
    logic bit_v;
    bit_v = 1'b0;
    unique case (code)
      eti_pkg::ETI_PORT_A: bit_v = p.pa[pin];
      eti_pkg::ETI_PORT_B: bit_v = p.pb[pin];
      eti_pkg::ETI_PORT_C: bit_v = p.pc[pin];
      eti_pkg::ETI_PORT_D: bit_v = p.pd[pin];
      eti_pkg::ETI_PORT_F: bit_v = p.pf[pin];
      // reserved codes feed no pin, so the line stays quiet
      default: bit_v = 1'b0;
    endcase
    return bit_v;
  endfunction : eti_pick

  // byte-lane merge that never lets reserved bits change
  function automatic logic [31:0] eti_merge(input logic [31:0] old_v,
                                            input logic [31:0] data,
                                            input logic [3:0] strb,
                                            input logic [31:0] mask);
    logic [31:0] lane;
    lane = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old_v & ~(lane & mask)) | (data & lane & mask);
  endfunction : eti_merge

  // aligned word address of a byte address
  function automatic logic [ADDR_W-1:0] eti_word(input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:2], 2'b00};
  endfunction : eti_word

  localparam logic [ADDR_W-1:0] A_EXTI = ADDR_W'(eti_pkg::ETI_OFS_EXTI_HI);
  localparam logic [ADDR_W-1:0] A_CMP = ADDR_W'(eti_pkg::ETI_OFS_CMP);
  localparam logic [ADDR_W-1:0] A_SMALL = ADDR_W'(eti_pkg::ETI_OFS_SMALL_TMR);
  localparam logic [ADDR_W-1:0] A_MAIN = ADDR_W'(eti_pkg::ETI_OFS_MAIN_TMR);

  // ------------------------------------------------------------------
  // next state: bus slave and routing
  // ------------------------------------------------------------------
  always_comb begin
    logic [3:0] t11;
    logic [3:0] t10;
    logic [3:0] t9;
    logic [2:0] t5;
    logic [2:0] t2;
    logic [3:0] t1;
    logic [1:0] cmp;
    logic [31:0] ex;
    s_nxt = s_r;
    ex = s_r.exti_src_sel_hi;
    cmp = s_r.comparator_out_remap[eti_pkg::ETI_CMP_LSB +: 2];
    t11 = s_r.small_timer_remap[eti_pkg::ETI_T11_LSB +: 4];
    t10 = s_r.small_timer_remap[eti_pkg::ETI_T10_LSB +: 4];
    t9 = s_r.small_timer_remap[eti_pkg::ETI_T9_LSB +: 4];
    t5 = s_r.main_timer_remap[eti_pkg::ETI_T5_LSB +: 3];
    t2 = s_r.main_timer_remap[eti_pkg::ETI_T2_LSB +: 3];
    t1 = s_r.main_timer_remap[eti_pkg::ETI_T1_LSB +: 4];

    // write address and data are taken independently
    if (s_r.awready && s_axi_awvalid_in) begin
      s_nxt.awready = 1'b0;
      s_nxt.waddr = s_axi_awaddr_in;
    end
    if (s_r.wready && s_axi_wvalid_in) begin
      s_nxt.wready = 1'b0;
      s_nxt.wdata = s_axi_wdata_in;
      s_nxt.wstrb = s_axi_wstrb_in;
    end
    // both halves held: commit and answer; masks keep reserved bits at 0
    if (!s_r.awready && !s_r.wready && !s_r.bvalid) begin
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = eti_pkg::ETI_RESP_OKAY;
      unique case (eti_word(s_r.waddr))
        A_EXTI: s_nxt.exti_src_sel_hi = eti_merge(s_r.exti_src_sel_hi,
          s_r.wdata, s_r.wstrb, eti_pkg::ETI_MSK_EXTI_HI);
        A_CMP: s_nxt.comparator_out_remap = eti_merge(
          s_r.comparator_out_remap, s_r.wdata, s_r.wstrb,
          eti_pkg::ETI_MSK_CMP);
        A_SMALL: s_nxt.small_timer_remap = eti_merge(s_r.small_timer_remap,
          s_r.wdata, s_r.wstrb, eti_pkg::ETI_MSK_SMALL_TMR);
        A_MAIN: s_nxt.main_timer_remap = eti_merge(s_r.main_timer_remap,
          s_r.wdata, s_r.wstrb, eti_pkg::ETI_MSK_MAIN_TMR);
        default: s_nxt.bresp = eti_pkg::ETI_RESP_SLVERR;
      endcase
    end
    // both channels reopen only once the response is gone
    if (s_r.bvalid && s_axi_bready_in) begin
      s_nxt.bvalid = 1'b0;
      s_nxt.awready = 1'b1;
      s_nxt.wready = 1'b1;
    end

    // reads answer one cycle after the address; write-only reads as zero
    if (s_r.arready && s_axi_arvalid_in) begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = eti_pkg::ETI_RESP_OKAY;
      s_nxt.rdata = 32'h0000_0000;
      unique case (eti_word(s_axi_araddr_in))
        A_EXTI: s_nxt.rdata = s_r.exti_src_sel_hi;
        A_CMP: s_nxt.rdata = 32'h0000_0000;
        A_SMALL: s_nxt.rdata = s_r.small_timer_remap;
        A_MAIN: s_nxt.rdata = s_r.main_timer_remap;
        default: s_nxt.rresp = eti_pkg::ETI_RESP_SLVERR;
      endcase
    end
    if (s_r.rvalid && s_axi_rready_in) begin
      s_nxt.rvalid = 1'b0;
      s_nxt.arready = 1'b1;
    end

    // interrupt line sources, from the registers as they stand now
    s_nxt.irq_src[15] = eti_pick(pins_in,
      ex[eti_pkg::ETI_EXTI15_LSB +: 4], 15);
    s_nxt.irq_src[14] = eti_pick(pins_in,
      ex[eti_pkg::ETI_EXTI14_LSB +: 4], 14);
    s_nxt.irq_src[13] = eti_pick(pins_in,
      ex[eti_pkg::ETI_EXTI13_LSB +: 4], 13);
    s_nxt.irq_src[12] = eti_pick(pins_in,
      ex[eti_pkg::ETI_EXTI12_LSB +: 4], 12);

    // undefined timer codes fall back to the reset pin set
    s_nxt.tmr.t11_ch1 = (t11 == eti_pkg::ETI_SMALL_ALT) ?
      pins_in.pa[7] : pins_in.pb[9];
    s_nxt.tmr.t10_ch1 = (t10 == eti_pkg::ETI_SMALL_ALT) ?
      pins_in.pa[6] : pins_in.pb[8];
    s_nxt.tmr.t9_ch = (t9 == eti_pkg::ETI_SMALL_ALT) ?
      pins_in.pb[15:14] : pins_in.pa[3:2];
    s_nxt.tmr.t5_ch[1:0] = (t5 == eti_pkg::ETI_T5_ALT) ?
      pins_in.pf[5:4] : pins_in.pa[1:0];
    s_nxt.tmr.t5_ch[2] = pins_in.pa[2];
    s_nxt.tmr.t5_ch[3] = s_r.main_timer_remap[eti_pkg::ETI_T5CH4_BIT] ?
      low_speed_rc_oscillator_in : pins_in.pa[3];

    // timer 2: low bit moves ch1/ch2, next bit moves ch3/ch4
    if (t2[2]) begin
      t2 = 3'h0;
    end
    s_nxt.tmr.t2_ch[0] = t2[0] ? pins_in.pa[15] : pins_in.pa[0];
    s_nxt.tmr.t2_ch[1] = t2[0] ? pins_in.pb[3] : pins_in.pa[1];
    s_nxt.tmr.t2_ch[3:2] = t2[1] ?
      pins_in.pb[11:10] : pins_in.pa[3:2];

    // timer 1 inputs, and its complementary outputs onto pins
    s_nxt.drv = '0;
    if (t1 == eti_pkg::ETI_T1_SET2) begin
      s_nxt.tmr.t1_ext = pins_in.pa[0];
      s_nxt.tmr.t1_ch = pins_in.pc[9:6];
    end else begin
      s_nxt.tmr.t1_ext = pins_in.pa[12];
      s_nxt.tmr.t1_ch = pins_in.pa[11:8];
    end
    if (t1 == eti_pkg::ETI_T1_SET1 || t1 == eti_pkg::ETI_T1_SET2) begin
      s_nxt.tmr.t1_brk = pins_in.pa[6];
      s_nxt.drv.pa_val[7] = complementary_channel_in[0];
      s_nxt.drv.pa_oe[7] = 1'b1;
      s_nxt.drv.pb_val[1:0] = complementary_channel_in[2:1];
      s_nxt.drv.pb_oe[1:0] = 2'h3;
    end else begin
      s_nxt.tmr.t1_brk = pins_in.pb[12];
      s_nxt.drv.pb_val[15:13] = complementary_channel_in;
      s_nxt.drv.pb_oe[15:13] = 3'h7;
    end

    // comparator outputs; a pin shared with timer 1 is OR-ed, not fought
    unique case (cmp)
      eti_pkg::ETI_CMP_PA0_PA2: begin
        s_nxt.drv.pa_val[0] = comparator_one_output_in;
        s_nxt.drv.pa_val[2] = comparator_two_output_in;
        s_nxt.drv.pa_oe[0] = 1'b1;
        s_nxt.drv.pa_oe[2] = 1'b1;
      end
      eti_pkg::ETI_CMP_PA6_PA7: begin
        s_nxt.drv.pa_val[6] = comparator_one_output_in;
        s_nxt.drv.pa_val[7] = s_nxt.drv.pa_val[7] |
          comparator_two_output_in;
        s_nxt.drv.pa_oe[6] = 1'b1;
        s_nxt.drv.pa_oe[7] = 1'b1;
      end
      eti_pkg::ETI_CMP_PA11_PA12: begin
        s_nxt.drv.pa_val[11] = comparator_one_output_in;
        s_nxt.drv.pa_val[12] = comparator_two_output_in;
        s_nxt.drv.pa_oe[11] = 1'b1;
        s_nxt.drv.pa_oe[12] = 1'b1;
      end
      // reserved code: comparators reach no pin
      default: begin
      end
    endcase
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_r <= '0;
      s_r.exti_src_sel_hi <= eti_pkg::ETI_RST_EXTI_HI;
      s_r.comparator_out_remap <= eti_pkg::ETI_RST_CMP;
      s_r.small_timer_remap <= eti_pkg::ETI_RST_SMALL_TMR;
      s_r.main_timer_remap <= eti_pkg::ETI_RST_MAIN_TMR;
      s_r.awready <= 1'b1;
      s_r.wready <= 1'b1;
      s_r.arready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------------
  // outputs, all straight from the state register
  // ------------------------------------------------------------------
  assign s_axi_awready_out = s_r.awready;
  assign s_axi_wready_out = s_r.wready;
  assign s_axi_bvalid_out = s_r.bvalid;
  assign s_axi_bresp_out = s_r.bresp;
  assign s_axi_arready_out = s_r.arready;
  assign s_axi_rvalid_out = s_r.rvalid;
  assign s_axi_rresp_out = s_r.rresp;
  assign s_axi_rdata_out = s_r.rdata;
  assign ext_irq_line_source_out = s_r.irq_src;
  assign timer_inputs_out = s_r.tmr;
  assign pin_drive_out = s_r.drv;

endmodule : eti_remap_top
`default_nettype wire

/* File: eti_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// pins, comparators and oscillator around the block
// ----------------------------------------------------------------
module eti_pin_model (
  input wire logic clk_sys_in,
  output eti_pkg::eti_pins_t pins_out,
  output logic [5:0] misc_out
);
  logic [85:0] lvl_r = 86'h1;
  // levels move every cycle, so a stale or wrong route shows
  always @(posedge clk_sys_in) begin
    lvl_r <= {lvl_r[84:0], lvl_r[85]} ^ (lvl_r << 13);
  end
  assign pins_out = lvl_r[79:0];
  assign misc_out = lvl_r[85:80]; // osc, compl 3..1, cmp2, cmp1
endmodule : eti_pin_model
`default_nettype wire

/* File: eti_remap_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// bus and routing checker
// ----------------------------------------------------------------
module eti_remap_chk (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire eti_pkg::eti_pins_t pins_in,
  input wire eti_pkg::eti_tmr_t timer_inputs_out
);
  logic up_r;
  logic both_t;
  // routes only have a past sample from the second edge on
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      up_r <= 1'b0;
    end else begin
      up_r <= 1'b1;
    end
  end
  // address and data taken at the same edge
  assign both_t = s_axi_awvalid_in && s_axi_awready_out &&
    s_axi_wvalid_in && s_axi_wready_out;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  wr_lat_a: assert property (
    both_t |=> !s_axi_bvalid_out ##1 s_axi_bvalid_out)
    else $error("write answer not two edges after request");
  aw_lock_a: assert property (
    both_t |=> (!s_axi_awready_out && !s_axi_wready_out) [*2])
    else $error("write ready back before answer");
  b_hold_a: assert property (
    s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write answer dropped or changed");
  rd_lat_a: assert property (
    s_axi_arvalid_in && s_axi_arready_out |=>
    s_axi_rvalid_out && !s_axi_arready_out)
    else $error("read answer late");
  r_hold_a: assert property (
    s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read answer dropped or changed");
  t5_ch3_a: assert property (
    up_r |-> timer_inputs_out.t5_ch[2] == $past(pins_in.pa[2]))
    else $error("timer five channel three not from port a pin 2");
  t9_pin_a: assert property (
    up_r |-> timer_inputs_out.t9_ch == $past(pins_in.pa[3:2]) ||
    timer_inputs_out.t9_ch == $past(pins_in.pb[15:14]))
    else $error("timer nine channels from wrong pins");
  t10_pin_a: assert property (
    up_r |-> timer_inputs_out.t10_ch1 == $past(pins_in.pa[6]) ||
    timer_inputs_out.t10_ch1 == $past(pins_in.pb[8]))
    else $error("timer ten channel one from wrong pin");
endmodule : eti_remap_chk
bind eti_remap_top eti_remap_chk i_chk (.clk_sys_in, .rst_b_in,
  .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in,
  .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out,
  .s_axi_bready_in, .s_axi_arvalid_in, .s_axi_arready_out,
  .s_axi_rdata_out, .s_axi_rvalid_out, .s_axi_rready_in, .pins_in,
  .timer_inputs_out);
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, chk_en = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] irq, ei, c, t1;
  logic [2:0] t2;
  logic [5:0] misc, mq;
  eti_pkg::eti_tmr_t tmr, et;
  eti_pkg::eti_drive_t drv, ed;
  eti_pkg::eti_pins_t pins, pq;
  logic [31:0] sh [4] = '{default: 32'h0};
  logic [31:0] msk [4] = '{eti_pkg::ETI_MSK_EXTI_HI, eti_pkg::ETI_MSK_CMP,
    eti_pkg::ETI_MSK_SMALL_TMR, eti_pkg::ETI_MSK_MAIN_TMR};
  logic [1:0] wq [$];
  logic [33:0] rq [$];
  int err_count = 0, checked = 0, i, j, k, p1, p2;
  initial forever #50 clk_sys_in = ~clk_sys_in;
  eti_pin_model i_pins (.clk_sys_in(clk_sys_in), .pins_out(pins),
    .misc_out(misc));
  eti_remap_top i_dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .pins_in(pins),
    .comparator_one_output_in(misc[0]), .comparator_two_output_in(misc[1]),
    .complementary_channel_in(misc[4:2]),
    .low_speed_rc_oscillator_in(misc[5]), .ext_irq_line_source_out(irq),
    .timer_inputs_out(tmr), .pin_drive_out(drv));
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  // one write, valid released per channel, answer taken late at times
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    int dly;
    logic [31:0] bm;
    dly = $urandom_range(3, 0);
    bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    chk_en = 1'b0;
    wq.push_back(a > 8'h0f ? eti_pkg::ETI_RESP_SLVERR : eti_pkg::ETI_RESP_OKAY);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys_in);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1 && bready === 1'b1) break;
      if (n == dly) bready <= 1'b1;
    end
    bready <= 1'b0;
    if (n == 40) begin
      err_count++;
      stop_test();
    end
    bm = bm & msk[a[3:2]];
    if (a < 8'h10) sh[a[3:2]] = (sh[a[3:2]] & ~bm) | (d & bm);
    @(posedge clk_sys_in);
    chk_en = 1'b1;
  endtask : wr
  // one read; the write-only word and holes read zero
  task automatic rd(input logic [7:0] a);
    int n;
    int dly;
    dly = $urandom_range(3, 0);
    rq.push_back(a > 8'h0f ? {eti_pkg::ETI_RESP_SLVERR, 32'h0} :
      {eti_pkg::ETI_RESP_OKAY, a[3:2] == 2'h1 ? 32'h0 : sh[a[3:2]]});
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys_in);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1 && rready === 1'b1) break;
      if (n == dly) rready <= 1'b1;
    end
    rready <= 1'b0;
    if (n == 40) begin
      err_count++;
      stop_test();
    end
  endtask : rd
  task automatic do_rst(input int n);
    chk_en = 1'b0;
    rst_b_in <= 1'b0;
    sh = '{default: 32'h0};
    repeat (n) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    @(posedge clk_sys_in);
    chk_en = 1'b1;
    for (i = 0; i < 5; i++) rd(8'(4 * i));
  endtask : do_rst
  // bus answers against the oldest expectation
  always @(posedge clk_sys_in) begin
    pq <= pins;
    mq <= misc;
    if (bvalid === 1'b1 && bready === 1'b1) chk(bresp, wq.pop_front());
    if (rvalid === 1'b1 && rready === 1'b1) chk({rresp, rdata}, rq.pop_front());
  end
  // routes from the shadow config and the pins of the last edge
  always @(negedge clk_sys_in) begin
    if (chk_en) begin
      // own loop index: the main sequence's k must not be disturbed
      for (int n = 0; n < 4; n++) begin
        c = sh[0][4*n +: 4];
        ei[n] = (c > 4'h4) ? 1'b0 : pq[16*c+12+n];
      end
      t1 = sh[3][3:0];
      t2 = sh[3][6] ? 3'h0 : sh[3][6:4];
      et.t1_ext = (t1 == 4'h2) ? pq.pa[0] : pq.pa[12];
      et.t1_ch = (t1 == 4'h2) ? pq.pc[9:6] : pq.pa[11:8];
      et.t1_brk = (t1 == 4'h1 || t1 == 4'h2) ? pq.pa[6] : pq.pb[12];
      et.t2_ch = {t2[1] ? pq.pb[11:10] : pq.pa[3:2],
        t2[0] ? {pq.pb[3], pq.pa[15]} : pq.pa[1:0]};
      et.t5_ch = {sh[3][19] ? mq[5] : pq.pa[3], pq.pa[2],
        (sh[3][18:16] == 3'h1) ? pq.pf[5:4] : pq.pa[1:0]};
      et.t9_ch = (sh[2][3:0] == 4'h2) ? pq.pb[15:14] : pq.pa[3:2];
      et.t10_ch1 = (sh[2][7:4] == 4'h2) ? pq.pa[6] : pq.pb[8];
      et.t11_ch1 = (sh[2][11:8] == 4'h2) ? pq.pa[7] : pq.pb[9];
      ed = '0;
      c = {2'h0, sh[1][27:26]};
      p1 = (c == 4'h0) ? 0 : (c == 4'h1) ? 6 : 11;
      p2 = (c == 4'h0) ? 2 : p1 + 1;
      if (c != 4'h3) begin
        ed.pa_oe[p1] = 1'b1;
        ed.pa_oe[p2] = 1'b1;
        ed.pa_val[p1] = mq[0];
        ed.pa_val[p2] = mq[1];
      end
      // shared pin 7: both drivers are or-ed
      if (t1 == 4'h1 || t1 == 4'h2) begin
        ed.pa_oe[7] = 1'b1;
        ed.pa_val[7] = ed.pa_val[7] | mq[2];
        ed.pb_oe[1:0] = 2'h3;
        ed.pb_val[1:0] = mq[4:3];
      end else begin
        ed.pb_oe[15:13] = 3'h7;
        ed.pb_val[15:13] = mq[4:2];
      end
      chk(irq, ei);
      chk(tmr, et);
      chk(drv, ed);
    end
  end
  // main sequence: every code of every field, holes, strobes, resets
  initial begin
    void'($urandom(32'hb6fb9202));
    do_rst(10);
    $display("test reset_values done");
    for (j = 0; j < 16; j++) begin
      for (k = 0; k < 4; k++) begin
        wr(8'(4 * k), {8{4'(j)}} & msk[k], 4'hf);
        rd(8'(4 * k));
      end
      repeat (6) @(posedge clk_sys_in);
    end
    $display("test all_codes done");
    wr(8'h10, $urandom(), 4'hf);
    wr(8'h00, 32'h0000_ffff, 4'h2);
    rd(8'h00);
    $display("test hole_and_strobe done");
    do_rst(2);
    $display("test second_reset done");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
